/* File: rtl/scda_defs.svh */
// Behaviour
// - Storage splits into a factory one-time-programmable block and writable registers.
// - Separate CRC checks run over the factory block and the writable block.
// - A lock stops changes to the writable block once normal operation starts.
// - Traceability bits 12..0 hold the serial, bits 31..13 hold the lot.
// - Traceability value sits in four consecutive read-only bytes at the map bottom.
// - Serials and lots count up from 1; not every value is used.
// - The four traceability bytes are covered by the factory block CRC.
// - Traceability bytes steer no device function; identification and CRC only.
// - Writes of reset bits 00, 11, 01 in a row reset the logic.
// - Device configuration is writable only until the init-complete lock is set.
`ifndef SCDA_DEFS_SVH
`define SCDA_DEFS_SVH

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define SCDA_ADDR_W           6
`define SCDA_ADDR_SERIAL0     6'h00
`define SCDA_ADDR_SERIAL1     6'h01
`define SCDA_ADDR_SERIAL2     6'h02
`define SCDA_ADDR_SERIAL3     6'h03
`define SCDA_ADDR_SELFTEST    6'h04
`define SCDA_ADDR_RSVD05      6'h05
`define SCDA_ADDR_FACTORY     6'h06
`define SCDA_ADDR_RANGE       6'h08
`define SCDA_ADDR_CONTROL     6'h0A
`define SCDA_ADDR_CONFIG      6'h0B
`define SCDA_ADDR_AXIS        6'h0C
`define SCDA_ADDR_ARMING      6'h0E
`define SCDA_ADDR_THR_POS     6'h10
`define SCDA_ADDR_THR_NEG     6'h12
`define SCDA_ADDR_DEVSTATE    6'h14
`define SCDA_ADDR_TALLY       6'h15
`define SCDA_ADDR_OFFSET      6'h16
`define SCDA_ADDR_RSVD1C      6'h1C
`define SCDA_ADDR_RSVD1D      6'h1D

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SCDA_CTL_RESET_HI     7
`define SCDA_CTL_RESET_LO     6
`define SCDA_CTL_PHASE_HI     5
`define SCDA_CTL_PHASE_LO     4
`define SCDA_CTL_OFFCFG_EN    3
`define SCDA_CTL_RSVD_HI      2
`define SCDA_CFG_LOCK         5
`define SCDA_STAT_CRC_FAULT   6
`define SCDA_STAT_INIT        4
`define SCDA_STAT_MISO_ERR    3
`define SCDA_STAT_OFFSET      1
`define SCDA_STAT_RESET_SEEN  0
`define SCDA_SERIAL_HI        12
`define SCDA_LOT_LO           13

// ------------------------------------------------------------
// Values
// ------------------------------------------------------------
`define SCDA_RESET_CODE_1     2'h0
`define SCDA_RESET_CODE_2     2'h3
`define SCDA_RESET_CODE_3     2'h1
`define SCDA_PHASE_NORMAL     2'h3
`define SCDA_BYTE_ZERO        8'h00
`define SCDA_CRC_POLY         8'h07
`define SCDA_CRC_INIT         8'hFF
`define SCDA_OTP_BYTES        7
`define SCDA_WR_BYTES         5

`endif

/* File: rtl/scda_pkg.sv */
package scda_pkg;

  // ------------------------------------------------------------
  // Reset sequence tracker
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SCDA_SEQ_IDLE  = 2'b00,
    SCDA_SEQ_GOT1  = 2'b01,
    SCDA_SEQ_GOT2  = 2'b10
  } scda_seq_t;

  // ------------------------------------------------------------
  // CRC walker state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [3:0] idx;
    logic [7:0] acc;
    logic [7:0] result;
    logic       done;
    logic       fault;
  } scda_crc_state_t;

  // ------------------------------------------------------------
  // Register bank state
  // ------------------------------------------------------------
  typedef struct packed {
    logic        loaded;
    logic [31:0] trace;
    logic [7:0]  selftest;
    logic [7:0]  factory_cfg;
    logic [7:0]  range_code;
    logic [7:0]  otp_crc;
    logic [1:0]  oc_phase;
    logic        offcfg_en;
    logic [2:0]  ctl_rsvd;
    logic [7:0]  dev_cfg;
    logic [7:0]  axis_cfg;
    logic [7:0]  arm_cfg;
    logic [7:0]  thr_pos;
    logic [7:0]  thr_neg;
    scda_seq_t   seq;
    logic        reset_seen;
    logic        soft_rst;
    logic [7:0]  wcrc_ref;
    logic        wcrc_armed;
    logic        rsp_valid;
    logic        rsp_invalid;
    logic [7:0]  rsp_data;
  } scda_state_t;

endpackage

/* File: rtl/scda_crc_walk.sv */
`timescale 1ns/100ps
`include "scda_defs.svh"

// Walks a byte vector one byte per cycle, forever, and compares each
// finished CRC with the expected value while checking is enabled.
module scda_crc_walk #(
  parameter int BYTES = 7
) (
  // Clock and control
  input  wire logic               ref_clk_i,
  input  wire logic               sys_rst_i,
  input  wire logic               ce_i,
  input  wire logic               restart_i,
  // Data under check
  input  wire logic [BYTES*8-1:0] data_i,
  input  wire logic [7:0]         expect_i,
  input  wire logic               check_en_i,
  // Results
  output logic [7:0]              result_o,
  output logic                    done_o,
  output logic                    fault_o
);

  // ------------------------------------------------------------
  // Byte step of the CRC
  // ------------------------------------------------------------
  function automatic logic [7:0] crc_byte(input logic [7:0] crc, input logic [7:0] d);
    logic [7:0] c;
    c = crc ^ d;
    for (int b = 0; b < 8; b++) begin
      c = c[7] ? ((c << 1) ^ `SCDA_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  scda_pkg::scda_crc_state_t st;
  scda_pkg::scda_crc_state_t next_st;
  logic [7:0]                byte_sel;
  logic [7:0]                acc_new;

  always_comb begin
    next_st  = st;
    byte_sel = data_i[st.idx*8 +: 8];
    acc_new  = crc_byte(st.acc, byte_sel);
    next_st.done = 1'b0;
    if (restart_i) begin
      next_st.idx   = '0;
      next_st.acc   = `SCDA_CRC_INIT;
      next_st.fault = 1'b0;
    end else if (st.idx == 4'(BYTES - 1)) begin
      next_st.idx    = '0;
      next_st.acc    = `SCDA_CRC_INIT;
      next_st.result = acc_new;
      next_st.done   = 1'b1;
      if (check_en_i && acc_new != expect_i) begin
        next_st.fault = 1'b1;
      end
    end else begin
      next_st.idx = st.idx + 4'h1;
      next_st.acc = acc_new;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st.idx    <= 4'h0;
      st.acc    <= `SCDA_CRC_INIT;
      st.result <= 8'h00;
      st.done   <= 1'b0;
      st.fault  <= 1'b0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign result_o = st.result;
  assign done_o   = st.done;
  assign fault_o  = st.fault;

endmodule

/* File: rtl/scda_regs.sv */
`timescale 1ns/100ps
`include "scda_defs.svh"

// Customer data array: factory shadow block, writable configuration
// block with lock, status readback and the soft reset sequencer.
module scda_regs (
  // Clock and reset
  input  wire logic                    ref_clk_i,
  input  wire logic                    sys_rst_i,
  input  wire logic                    ce_i,
  // Register command port
  input  wire logic                    cmd_valid_i,
  input  wire logic                    cmd_write_i,
  input  wire logic [`SCDA_ADDR_W-1:0] cmd_addr_i,
  input  wire logic [7:0]              cmd_wdata_i,
  // Register answer
  output logic                         rsp_valid_o,
  output logic                         rsp_invalid_o,
  output logic [7:0]                   rsp_data_o,
  // Factory block contents
  input  wire logic [31:0]             otp_trace_i,
  input  wire logic [7:0]              otp_selftest_i,
  input  wire logic [7:0]              otp_factory_i,
  input  wire logic [7:0]              otp_range_i,
  input  wire logic [7:0]              otp_crc_i,
  // Status from the sensor core
  input  wire logic [7:0]              sample_tally_i,
  input  wire logic [7:0]              offset_correction_i,
  input  wire logic                    offset_flag_i,
  input  wire logic                    miso_err_i,
  // Configuration to the sensor core
  output logic [7:0]                   device_config_o,
  output logic [7:0]                   axis_config_o,
  output logic [7:0]                   arming_config_o,
  output logic [7:0]                   arming_threshold_pos_o,
  output logic [7:0]                   arming_threshold_neg_o,
  output logic [1:0]                   oc_phase_o,
  output logic                         offcfg_en_o,
  output logic                         init_complete_lock_o,
  // Identification and faults
  output logic [12:0]                  trace_serial_o,
  output logic [18:0]                  trace_lot_o,
  output logic                         otp_crc_fault_o,
  output logic                         reg_crc_fault_o,
  output logic                         soft_reset_o
);

  scda_pkg::scda_state_t st;
  scda_pkg::scda_state_t next_st;

  // ------------------------------------------------------------
  // CRC checkers, one per block
  // ------------------------------------------------------------
  logic [`SCDA_OTP_BYTES*8-1:0] otp_vec;
  logic [`SCDA_WR_BYTES*8-1:0]  wr_vec;
  logic [7:0]                   wcrc_result;
  logic                         wcrc_done;
  logic                         restart;
  logic                         wr_restart;

  assign restart = st.soft_rst || !st.loaded;
  assign otp_vec = {st.range_code, st.factory_cfg, st.selftest, st.trace};
  assign wr_vec  = {st.thr_neg, st.thr_pos, st.arm_cfg, st.axis_cfg, st.dev_cfg};

  scda_crc_walk #(
    .BYTES (`SCDA_OTP_BYTES)
  ) u_otp_crc (
    .ref_clk_i  (ref_clk_i),
    .sys_rst_i  (sys_rst_i),
    .ce_i       (ce_i),
    .restart_i  (restart),
    .data_i     (otp_vec),
    .expect_i   (st.otp_crc),
    .check_en_i (st.loaded),
    .result_o   (),
    .done_o     (),
    .fault_o    (otp_crc_fault_o)
  );

  scda_crc_walk #(
    .BYTES (`SCDA_WR_BYTES)
  ) u_wr_crc (
    .ref_clk_i  (ref_clk_i),
    .sys_rst_i  (sys_rst_i),
    .ce_i       (ce_i),
    .restart_i  (wr_restart),
    .data_i     (wr_vec),
    .expect_i   (st.wcrc_ref),
    .check_en_i (st.wcrc_armed),
    .result_o   (wcrc_result),
    .done_o     (wcrc_done),
    .fault_o    (reg_crc_fault_o)
  );

  // ------------------------------------------------------------
  // Read decode
  // ------------------------------------------------------------
  logic locked;
  logic [7:0] ctl_view;
  logic [7:0] stat_view;

  assign locked   = st.dev_cfg[`SCDA_CFG_LOCK];
  // Lock rise restarts the pass so the reference never mixes pre-lock bytes
  assign wr_restart = restart || (next_st.dev_cfg[`SCDA_CFG_LOCK] && !locked);
  assign ctl_view = {2'b00, st.oc_phase, st.offcfg_en, st.ctl_rsvd};
  always_comb begin
    stat_view = `SCDA_BYTE_ZERO;
    stat_view[`SCDA_STAT_CRC_FAULT]  = otp_crc_fault_o || reg_crc_fault_o;
    stat_view[`SCDA_STAT_INIT]       = !locked;
    stat_view[`SCDA_STAT_MISO_ERR]   = miso_err_i;
    stat_view[`SCDA_STAT_OFFSET]     = offset_flag_i;
    stat_view[`SCDA_STAT_RESET_SEEN] = st.reset_seen;
  end

  // Returns {mapped, value}; reserved locations are mapped and read zero
  function automatic logic [8:0] reg_read(input logic [`SCDA_ADDR_W-1:0] a);
    unique case (a)
      `SCDA_ADDR_SERIAL0:  return {1'b1, st.trace[7:0]};
      `SCDA_ADDR_SERIAL1:  return {1'b1, st.trace[15:8]};
      `SCDA_ADDR_SERIAL2:  return {1'b1, st.trace[23:16]};
      `SCDA_ADDR_SERIAL3:  return {1'b1, st.trace[31:24]};
      `SCDA_ADDR_SELFTEST: return {1'b1, st.selftest};
      `SCDA_ADDR_RSVD05:   return {1'b1, `SCDA_BYTE_ZERO};
      `SCDA_ADDR_FACTORY:  return {1'b1, st.factory_cfg};
      `SCDA_ADDR_RANGE:    return {1'b1, st.range_code};
      `SCDA_ADDR_CONTROL:  return {1'b1, ctl_view};
      `SCDA_ADDR_CONFIG:   return {1'b1, st.dev_cfg};
      `SCDA_ADDR_AXIS:     return {1'b1, st.axis_cfg};
      `SCDA_ADDR_ARMING:   return {1'b1, st.arm_cfg};
      `SCDA_ADDR_THR_POS:  return {1'b1, st.thr_pos};
      `SCDA_ADDR_THR_NEG:  return {1'b1, st.thr_neg};
      `SCDA_ADDR_DEVSTATE: return {1'b1, stat_view};
      `SCDA_ADDR_TALLY:    return {1'b1, sample_tally_i};
      `SCDA_ADDR_OFFSET:   return {1'b1, offset_correction_i};
      `SCDA_ADDR_RSVD1C:   return {1'b1, `SCDA_BYTE_ZERO};
      `SCDA_ADDR_RSVD1D:   return {1'b1, `SCDA_BYTE_ZERO};
      default:             return {1'b0, `SCDA_BYTE_ZERO};
    endcase
  endfunction

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  logic [8:0] rd;
  logic [1:0] res_code;
  logic       is_ctl;

  always_comb begin
    next_st  = st;
    rd       = reg_read(cmd_addr_i);
    res_code = {cmd_wdata_i[`SCDA_CTL_RESET_HI], cmd_wdata_i[`SCDA_CTL_RESET_LO]};
    is_ctl   = cmd_addr_i == `SCDA_ADDR_CONTROL;
    next_st.rsp_valid = 1'b0;
    next_st.soft_rst  = 1'b0;

    // Factory block is copied into the shadow once after each reset
    if (!st.loaded) begin
      next_st.loaded     = 1'b1;
      next_st.trace      = otp_trace_i;
      next_st.selftest   = otp_selftest_i;
      next_st.factory_cfg = otp_factory_i;
      next_st.range_code = otp_range_i;
      next_st.otp_crc    = otp_crc_i;
    end

    // Reference CRC of the writable block is taken once it is locked
    if (locked && !st.wcrc_armed && wcrc_done) begin
      next_st.wcrc_ref   = wcrc_result;
      next_st.wcrc_armed = 1'b1;
    end

    if (cmd_valid_i) begin
      next_st.rsp_valid   = 1'b1;
      next_st.rsp_invalid = !rd[8];
      next_st.rsp_data    = rd[7:0];

      // Any command that is not the awaited step ends the sequence
      next_st.seq = scda_pkg::SCDA_SEQ_IDLE;
      if (cmd_write_i && is_ctl) begin
        unique case (st.seq)
          scda_pkg::SCDA_SEQ_GOT1: begin
            if (res_code == `SCDA_RESET_CODE_2) begin
              next_st.seq = scda_pkg::SCDA_SEQ_GOT2;
            end
          end
          scda_pkg::SCDA_SEQ_GOT2: begin
            if (res_code == `SCDA_RESET_CODE_3) begin
              next_st.soft_rst = 1'b1;
            end
          end
          default: begin
          end
        endcase
        if (res_code == `SCDA_RESET_CODE_1) begin
          next_st.seq = scda_pkg::SCDA_SEQ_GOT1;
        end
      end

      if (cmd_write_i && rd[8] && !locked) begin
        unique case (cmd_addr_i)
          `SCDA_ADDR_CONTROL: begin
            next_st.offcfg_en = cmd_wdata_i[`SCDA_CTL_OFFCFG_EN];
            next_st.ctl_rsvd  = cmd_wdata_i[`SCDA_CTL_RSVD_HI:0];
            if (cmd_wdata_i[`SCDA_CTL_OFFCFG_EN]) begin
              next_st.oc_phase = cmd_wdata_i[`SCDA_CTL_PHASE_HI:`SCDA_CTL_PHASE_LO];
            end
          end
          `SCDA_ADDR_CONFIG:  next_st.dev_cfg  = cmd_wdata_i;
          `SCDA_ADDR_AXIS:    next_st.axis_cfg = cmd_wdata_i;
          `SCDA_ADDR_ARMING:  next_st.arm_cfg  = cmd_wdata_i;
          `SCDA_ADDR_THR_POS: next_st.thr_pos  = cmd_wdata_i;
          `SCDA_ADDR_THR_NEG: next_st.thr_neg  = cmd_wdata_i;
          default: begin
          end
        endcase
      end

      // Reading the state register acknowledges the reset indication
      if (!cmd_write_i && cmd_addr_i == `SCDA_ADDR_DEVSTATE) begin
        next_st.reset_seen = 1'b0;
      end
    end

    // Completed sequence returns the bank to its reset values
    if (next_st.soft_rst) begin
      next_st.loaded     = 1'b0;
      next_st.oc_phase   = 2'h0;
      next_st.offcfg_en  = 1'b0;
      next_st.ctl_rsvd   = 3'h0;
      next_st.dev_cfg    = `SCDA_BYTE_ZERO;
      next_st.axis_cfg   = `SCDA_BYTE_ZERO;
      next_st.arm_cfg    = `SCDA_BYTE_ZERO;
      next_st.thr_pos    = `SCDA_BYTE_ZERO;
      next_st.thr_neg    = `SCDA_BYTE_ZERO;
      next_st.wcrc_armed = 1'b0;
      next_st.reset_seen = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st            <= '0;
      st.seq        <= scda_pkg::SCDA_SEQ_IDLE;
      st.reset_seen <= 1'b1;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign rsp_valid_o            = st.rsp_valid;
  assign rsp_invalid_o          = st.rsp_invalid;
  assign rsp_data_o             = st.rsp_data;
  assign device_config_o        = st.dev_cfg;
  assign axis_config_o          = st.axis_cfg;
  assign arming_config_o        = st.arm_cfg;
  assign arming_threshold_pos_o = st.thr_pos;
  assign arming_threshold_neg_o = st.thr_neg;
  assign init_complete_lock_o   = locked;
  // Once locked the phase runs normal regardless of stored bits
  assign oc_phase_o             = locked ? `SCDA_PHASE_NORMAL : st.oc_phase;
  assign offcfg_en_o            = st.offcfg_en && !locked;
  // Identification only; drives nothing inside the bank
  assign trace_serial_o         = st.trace[`SCDA_SERIAL_HI:0];
  assign trace_lot_o            = st.trace[31:`SCDA_LOT_LO];
  assign soft_reset_o           = st.soft_rst;

endmodule

/* File: testbench/scda_regs_props.sv */
`timescale 1ns/100ps
`include "scda_defs.svh"

module scda_regs_props (
  // Clock and reset
  input wire logic                    ref_clk_i,
  input wire logic                    sys_rst_i,
  input wire logic                    ce_i,
  // Command and answer
  input wire logic                    cmd_valid_i,
  input wire logic                    cmd_write_i,
  input wire logic [`SCDA_ADDR_W-1:0] cmd_addr_i,
  input wire logic [7:0]              cmd_wdata_i,
  input wire logic                    rsp_valid_o,
  input wire logic                    rsp_invalid_o,
  input wire logic [7:0]              rsp_data_o,
  // Configuration and identity
  input wire logic [7:0]              device_config_o,
  input wire logic [7:0]              axis_config_o,
  input wire logic [1:0]              oc_phase_o,
  input wire logic                    offcfg_en_o,
  input wire logic                    init_complete_lock_o,
  input wire logic [12:0]             trace_serial_o,
  input wire logic [18:0]             trace_lot_o,
  input wire logic                    soft_reset_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic take;
  logic seq_end;
  assign take = cmd_valid_i && ce_i;
  // Last cycle took a control write with reset bits 01, whatever came before it
  always_ff @(posedge ref_clk_i) begin
    seq_end <= take && cmd_write_i && cmd_addr_i == 6'h0A && cmd_wdata_i[7:6] == 2'h1;
  end

  property p_ans; take |=> rsp_valid_o; endproperty
  a_ans: assert property (p_ans) else $error("command not answered");
  property p_unmap; take && cmd_addr_i == 6'h07 |=> rsp_invalid_o && rsp_data_o == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped not refused");
  property p_low; take && !cmd_write_i && cmd_addr_i == 6'h00 |=>
    rsp_data_o == trace_serial_o[7:0]; endproperty
  a_low: assert property (p_low) else $error("low trace byte wrong");
  property p_top; take && !cmd_write_i && cmd_addr_i == 6'h03 |=>
    rsp_data_o == trace_lot_o[18:11]; endproperty
  a_top: assert property (p_top) else $error("top trace byte wrong");
  property p_lock; init_complete_lock_o ##1 !soft_reset_o |->
    $stable(device_config_o) && $stable(axis_config_o); endproperty
  a_lock: assert property (p_lock) else $error("locked config changed");
  property p_phase; init_complete_lock_o |-> oc_phase_o == 2'h3 && !offcfg_en_o; endproperty
  a_phase: assert property (p_phase) else $error("phase not normal when locked");
  property p_cause; soft_reset_o |-> seq_end; endproperty
  a_cause: assert property (p_cause) else $error("soft reset without sequence");
  property p_clear; soft_reset_o |-> device_config_o == 8'h00 && !init_complete_lock_o;
  endproperty
  a_clear: assert property (p_clear) else $error("soft reset left config");
  property p_ctl; take && cmd_addr_i == 6'h0A |=> rsp_data_o[7:6] == 2'h0; endproperty
  a_ctl: assert property (p_ctl) else $error("reset bits read back set");
endmodule

bind scda_regs scda_regs_props i_scda_regs_props (
  .ref_clk_i, .sys_rst_i, .ce_i, .cmd_valid_i, .cmd_write_i, .cmd_addr_i, .cmd_wdata_i,
  .rsp_valid_o, .rsp_invalid_o, .rsp_data_o, .device_config_o, .axis_config_o,
  .oc_phase_o, .offcfg_en_o, .init_complete_lock_o, .trace_serial_o, .trace_lot_o,
  .soft_reset_o
);

/* File: testbench/scda_host.sv */
`timescale 1ns/100ps

// Host side: one register command at a time, answer taken one cycle later
module scda_host (
  // Clock
  input  wire logic       ref_clk_i,
  // Command out
  output logic            cmd_valid_o,
  output logic            cmd_write_o,
  output logic [5:0]      cmd_addr_o,
  output logic [7:0]      cmd_wdata_o,
  // Answer in
  input  wire logic       rsp_valid_i,
  input  wire logic       rsp_invalid_i,
  input  wire logic [7:0] rsp_data_i
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_addr_o  = 6'h00;
    cmd_wdata_o = 8'h00;
  end

  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
                      output logic [9:0] q);
    @(posedge ref_clk_i);
    cmd_valid_o <= 1'b1;
    cmd_write_o <= w;
    cmd_addr_o  <= a;
    cmd_wdata_o <= d;
    @(posedge ref_clk_i);
    // Released lines show the inverse so stale values cannot pass
    cmd_valid_o <= 1'b0;
    cmd_write_o <= ~w;
    cmd_addr_o  <= ~a;
    cmd_wdata_o <= ~d;
    @(posedge ref_clk_i);
    q = {rsp_valid_i, rsp_invalid_i, rsp_data_i};
  endtask

  // Three consecutive control writes: 00, 11, 01 in the top bits
  task automatic soft_reset();
    logic [9:0] q;
    xfer(1'b1, 6'h0A, 8'h00, q);
    xfer(1'b1, 6'h0A, 8'hC0, q);
    xfer(1'b1, 6'h0A, 8'h40, q);
  endtask
endmodule

/* File: testbench/sensor_config_data_array_tb.sv */
`timescale 1ns/100ps

module sensor_config_data_array_tb;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        ref_clk_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1, sr_seen = 1'b0;
  logic        offset_flag_i = 1'b0, miso_err_i = 1'b1;
  logic [31:0] otp_trace_i = 32'h800ABABC;
  logic [7:0]  otp_selftest_i = 8'h5A, otp_factory_i = 8'h80, otp_range_i = 8'hFF, otp_crc_i;
  logic [7:0]  sample_tally_i = 8'h3C, offset_correction_i = 8'hC3;
  logic        cmd_valid_i, cmd_write_i, rsp_valid_o, rsp_invalid_o, offcfg_en_o;
  logic [5:0]  cmd_addr_i;
  logic [7:0]  cmd_wdata_i, rsp_data_o, device_config_o, axis_config_o, arming_config_o;
  logic [7:0]  arming_threshold_pos_o, arming_threshold_neg_o;
  logic [1:0]  oc_phase_o;
  logic        init_complete_lock_o, otp_crc_fault_o, reg_crc_fault_o, soft_reset_o;
  logic [12:0] trace_serial_o;
  logic [18:0] trace_lot_o;
  logic [9:0]  q;
  logic [5:0]  bad [6] = '{6'h07, 6'h09, 6'h0D, 6'h13, 6'h1B, 6'h3F};
  int          fails = 0, tests_run = 0, cycles = 0;

  scda_regs i_scda_regs (
    .ref_clk_i, .sys_rst_i, .ce_i, .cmd_valid_i, .cmd_write_i, .cmd_addr_i, .cmd_wdata_i,
    .rsp_valid_o, .rsp_invalid_o, .rsp_data_o, .otp_trace_i, .otp_selftest_i, .otp_factory_i,
    .otp_range_i, .otp_crc_i, .sample_tally_i, .offset_correction_i, .offset_flag_i,
    .miso_err_i, .device_config_o, .axis_config_o, .arming_config_o, .arming_threshold_pos_o,
    .arming_threshold_neg_o, .oc_phase_o, .offcfg_en_o, .init_complete_lock_o,
    .trace_serial_o, .trace_lot_o, .otp_crc_fault_o, .reg_crc_fault_o, .soft_reset_o
  );
  scda_host i_scda_host (
    .ref_clk_i, .cmd_valid_o(cmd_valid_i), .cmd_write_o(cmd_write_i), .cmd_addr_o(cmd_addr_i),
    .cmd_wdata_o(cmd_wdata_i), .rsp_valid_i(rsp_valid_o), .rsp_invalid_i(rsp_invalid_o),
    .rsp_data_i(rsp_data_o)
  );

  always #2 ref_clk_i = ~ref_clk_i;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (soft_reset_o === 1'b1) sr_seen <= 1'b1;
    if (cycles == 2000) begin
      fails++;
      wrap_up();
    end
  end

  // CRC-8, polynomial 07, start FF, lowest byte first
  function automatic logic [7:0] crc8(input logic [55:0] v);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 0; i < 7; i++) begin
      c ^= v[i*8+:8];
      for (int b = 0; b < 8; b++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  function automatic logic [9:0] ok(input logic [7:0] d);
    return {2'b10, d};
  endfunction

  task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rd(input logic [5:0] a, input logic [9:0] e);
    i_scda_host.xfer(1'b0, a, 8'h00, q);
    chk($sformatf("read %h", a), e, q);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    i_scda_host.xfer(1'b1, a, d, q);
    chk($sformatf("write %h", a), 1'b1, q[9]);
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    otp_crc_i = crc8({otp_range_i, otp_factory_i, otp_selftest_i, otp_trace_i});
    repeat (8) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    for (int i = 0; i < 4; i++) rd(i[5:0], ok(otp_trace_i[i*8+:8]));
    chk("serial", 13'h1ABC, trace_serial_o);
    chk("lot", 19'h40055, trace_lot_o);
    rd(6'h04, ok(8'h5A));
    rd(6'h06, ok(8'h80));
    rd(6'h08, ok(8'hFF));
    rd(6'h05, ok(8'h00));
    rd(6'h16, ok(8'hC3));
    rd(6'h15, ok(8'h3C));
    wr(6'h00, 8'h11);
    rd(6'h00, ok(8'hBC));
    $display("test identity done");
    foreach (bad[i]) begin
      rd(bad[i], 10'h300);
      wr(bad[i], 8'hFF);
    end
    rd(6'h0B, ok(8'h00));
    $display("test unmapped done");
    wr(6'h0B, 8'h07);
    wr(6'h0C, 8'h8A);
    ce_i <= 1'b0;
    i_scda_host.xfer(1'b1, 6'h0C, 8'h55, q);
    chk("frozen", 9'h08A, {q[9], axis_config_o});
    ce_i <= 1'b1;
    wr(6'h0E, 8'h21);
    wr(6'h10, 8'h44);
    wr(6'h12, 8'h88);
    chk("arm", 16'h2144, {arming_config_o, arming_threshold_pos_o});
    chk("thr_neg", 8'h88, arming_threshold_neg_o);
    wr(6'h0A, 8'h18);
    chk("phase", 3'h3, {oc_phase_o, offcfg_en_o});
    rd(6'h0B, ok(8'h07));
    wr(6'h0B, 8'h27);
    chk("locked", 3'h7, {init_complete_lock_o, oc_phase_o});
    wr(6'h0B, 8'h00);
    wr(6'h0C, 8'h00);
    chk("cfg", 16'h278A, {device_config_o, axis_config_o});
    rd(6'h0A, ok(8'h18));
    repeat (30) @(posedge ref_clk_i);
    chk("crc", 2'h0, {otp_crc_fault_o, reg_crc_fault_o});
    rd(6'h14, ok(8'h09));
    $display("test lock done");
    wr(6'h0A, 8'h00);
    rd(6'h14, ok(8'h08));
    wr(6'h0A, 8'hC0);
    wr(6'h0A, 8'h40);
    wr(6'h0A, 8'h00);
    wr(6'h0A, 8'hC0);
    wr(6'h10, 8'h00);
    wr(6'h0A, 8'h40);
    repeat (2) @(posedge ref_clk_i);
    chk("abort", 2'h1, {sr_seen, init_complete_lock_o});
    otp_trace_i <= 32'h00004001;
    offset_flag_i <= 1'b1;
    i_scda_host.soft_reset();
    @(posedge ref_clk_i);
    chk("sreset", 18'h20000, {sr_seen, init_complete_lock_o, device_config_o, axis_config_o});
    chk("armclr", 16'h0000, {arming_config_o, arming_threshold_neg_o});
    repeat (30) @(posedge ref_clk_i);
    chk("crc", 2'h2, {otp_crc_fault_o, reg_crc_fault_o});
    rd(6'h14, ok(8'h5B));
    rd(6'h01, ok(8'h40));
    chk("serial", 13'h0001, trace_serial_o);
    chk("lot", 19'h00002, trace_lot_o);
    $display("test reset sequence done");
    wrap_up();
  end
endmodule
